// ---- verilog/sclf_pkg.sv ----
// shared constants and types for the serial command line front end
package sclf_pkg;
    // character codes
    localparam logic [7:0] CH_BS   = 8'h08;
    localparam logic [7:0] CH_LF   = 8'h0A;
    localparam logic [7:0] CH_CR   = 8'h0D;
    localparam logic [7:0] CH_XON  = 8'h11;
    localparam logic [7:0] CH_XOFF = 8'h13;
    localparam logic [7:0] CH_NAK  = 8'h15;
    localparam logic [7:0] CH_CAN  = 8'h18;
    localparam logic [7:0] CH_ESC  = 8'h1B;
    localparam logic [7:0] CH_SP   = 8'h20;
    localparam logic [7:0] CH_BANG = 8'h21;
    localparam logic [7:0] CH_GT   = 8'h3E;
    localparam logic [7:0] CTRL_TOP = 8'h1F;
    // frame format
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    // line buffer and transmit queue sizes
    localparam int LINE_DEPTH = 128;
    localparam int LINE_AW    = 7;
    localparam int TXQ_DEPTH  = 16;
    localparam int TXQ_AW     = 4;
    // baud divider: clocks per bit at reset
    localparam logic [15:0] BAUD_DIV_RST = 16'h0082;
    // reset values of mode bits
    localparam logic FLOW_EN_RST   = 1'b1;
    localparam logic PROMPT_EN_RST = 1'b0;
    localparam logic ECHO_EN_RST   = 1'b0;
    // status bit positions
    localparam int ST_XOFF  = 0;
    localparam int ST_LOSS  = 1;
    localparam int ST_LINE  = 2;
    // register offsets
    localparam logic [3:0] REG_MODE   = 4'h0;
    localparam logic [3:0] REG_BAUD   = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;

    // one received character handed up by the serial receiver
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sclf_char_t;

    // mode settings from software
    typedef struct packed {
        logic        flow_en;
        logic        echo_en;
        logic        prompt_en;
        logic [15:0] baud_div;
    } sclf_mode_t;
endpackage

// ---- verilog/sclf_bit_engine.sv ----
// serial bit engine: receive and transmit of 8N1 frames
`timescale 1ns/1ps
module sclf_bit_engine
    import sclf_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // baud
    input  wire logic [15:0] baud_div_in,
    // serial pins
    input  wire logic        rxd_in,
    output logic             txd_out,
    // received character
    output sclf_char_t       rx_out,
    // transmit request
    input  wire logic        tx_go_in,
    input  wire logic [7:0]  tx_data_in,
    output logic             tx_busy_out
);
    logic [15:0] rx_cnt_q;
    logic [3:0]  rx_bit_q;
    logic [7:0]  rx_sh_q;
    logic        rx_act_q;
    logic [15:0] tx_cnt_q;
    logic [3:0]  tx_bit_q;
    logic [9:0]  tx_sh_q;
    wire  [15:0] half_div = {1'b0, baud_div_in[15:1]};
    wire         rx_tick  = (rx_cnt_q == 16'h0000);
    wire         tx_tick  = (tx_cnt_q == 16'h0000);

    // receiver: start at falling edge, sample mid bit, lsb first
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 4'h0;
            rx_sh_q  <= 8'h00;
            rx_act_q <= 1'b0;
            rx_out   <= '0;
        end else begin
            rx_out.valid <= 1'b0;
            if (!rx_act_q) begin
                if (!rxd_in) begin
                    rx_act_q <= 1'b1;
                    rx_cnt_q <= half_div;
                    rx_bit_q <= 4'h0;
                end
            end else if (!rx_tick) begin
                rx_cnt_q <= rx_cnt_q - 16'h0001;
            end else begin
                rx_cnt_q <= baud_div_in - 16'h0001;
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h0) begin
                    rx_act_q <= ~rxd_in; // false start filter
                end else if (rx_bit_q <= 4'(DATA_BITS)) begin
                    rx_sh_q <= {rxd_in, rx_sh_q[7:1]}; // R22
                end else begin
                    rx_act_q     <= 1'b0;
                    rx_out.valid <= rxd_in; // framing error drops char
                    rx_out.data  <= rx_sh_q;
                end
            end
        end
    end

    // transmitter: start, 8 data lsb first, stop
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_cnt_q    <= 16'h0000;
            tx_bit_q    <= 4'h0;
            tx_sh_q     <= 10'h3FF;
            txd_out     <= 1'b1;
            tx_busy_out <= 1'b0;
        end else if (tx_go_in && !tx_busy_out) begin
            tx_sh_q     <= {1'b1, tx_data_in, 1'b0}; // R22
            tx_bit_q    <= 4'(DATA_BITS + STOP_BITS + 1);
            tx_cnt_q    <= 16'h0000;
            tx_busy_out <= 1'b1;
        end else if (tx_busy_out) begin
            if (!tx_tick) begin
                tx_cnt_q <= tx_cnt_q - 16'h0001;
            end else if (tx_bit_q == 4'h0) begin
                tx_busy_out <= 1'b0;
            end else begin
                txd_out  <= tx_sh_q[0];
                tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
                tx_bit_q <= tx_bit_q - 4'h1;
                tx_cnt_q <= baud_div_in - 16'h0001;
            end
        end
    end
endmodule

// ---- verilog/sclf_top.sv ----
// serial command line front end: line editing, echo, flow control
`timescale 1ns/1ps
// What this block does and what the host must do
// R1: reset to 8N1, flow control on, prompt off
// R2: CR or LF ends line, hands to parser
// R3: ESC empties buffer, sends CR LF
// R4: BS removes last char, never terminators
// R5: other control codes 00-1F ignored
// R6: after dispatch, send CR LF
// R7: XON enables transmitter under flow control
// R8: XOFF halts transmit until XON
// R9: CAN clears both pointers and queues
// R10: XOFF posts queue loss error
// R11: on XON drain queue then send bang
// R12: echo mode returns every char stored in the line
// R13: backspace echoes BS space BS
// R14: CR LF pair echoes first only
// R15: terminator answered XOFF CR or XOFF
// R16: host obeys XON and XOFF
// R17: echo overflow sends NAK, posts error
// R18: host keeps lines within 127 chars
// R19: prompt mode sends CR LF greater-than
// R20: host waits for prompt per line
// R21: host verifies echo before terminators
// R22: frame start, 8 data lsb first, stop
module sclf_top
    import sclf_pkg::*;
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // serial pins
    input  wire logic        rxd_in,
    output logic             txd_out,
    // register port
    input  wire logic [3:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    // parser side: line read and dispatch done
    output logic             line_ready_out,
    output logic [6:0]       line_len_out,
    input  wire logic [6:0]  line_idx_in,
    output logic [7:0]       line_char_out,
    input  wire logic        line_done_in,
    // error queue post
    output logic             queue_loss_error_out
);
    logic [1:0] rst_sync_q;
    wire        rst_n = rst_sync_q[1];

    // reset release through two flops
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    sclf_mode_t mode_q;
    logic       loss_q;
    logic       xoff_q;
    sclf_char_t rx;
    logic       tx_busy;
    logic       tx_go_q;
    logic [7:0] tx_byte_q;

    sclf_bit_engine u_bits (
        .clk_in      (clock_in),
        .rst_n_in    (rst_n),
        .baud_div_in (mode_q.baud_div),
        .rxd_in      (rxd_in),
        .txd_out     (txd_out),
        .rx_out      (rx),
        .tx_go_in    (tx_go_q),
        .tx_data_in  (tx_byte_q),
        .tx_busy_out (tx_busy)
    );

    // character classes, decoded once
    function automatic logic is_term(input logic [7:0] c);
        return (c == CH_CR) || (c == CH_LF);
    endfunction

    wire [7:0] ch      = rx.data;
    wire       c_term  = rx.valid && is_term(ch);
    wire       c_bs    = rx.valid && (ch == CH_BS);
    wire       c_esc   = rx.valid && (ch == CH_ESC);
    wire       c_can   = rx.valid && (ch == CH_CAN);
    wire       c_xon   = rx.valid && (ch == CH_XON) && mode_q.flow_en;
    wire       c_xoff  = rx.valid && (ch == CH_XOFF) && mode_q.flow_en;
    wire       c_ctrl  = rx.valid && (ch <= CTRL_TOP);
    wire       c_print = rx.valid && !c_ctrl; // R5

    // line buffer
    logic [7:0] line_mem_q [LINE_DEPTH];
    logic [6:0] wptr_q;
    logic       locked_q;     // line handed over, waiting for parser
    logic       prev_term_q;  // last char, flow codes aside, was a terminator but not a pair tail
    logic [7:0] prev_ch_q;

    wire buf_full  = (wptr_q == 7'(LINE_DEPTH - 1));
    wire do_store  = c_print && !locked_q && !buf_full;
    wire do_bs     = c_bs && !locked_q && (wptr_q != 7'h00); // R4
    wire pair_tail = c_term && prev_term_q && (ch != prev_ch_q); // R14
    wire do_term   = c_term && !locked_q && !pair_tail; // R2

    // buffer write and pointer
    always_ff @(posedge clock_in) begin
        if (do_store) begin
            line_mem_q[wptr_q] <= ch;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wptr_q      <= 7'h00;
            locked_q    <= 1'b0;
            prev_term_q <= 1'b0;
            prev_ch_q   <= 8'h00;
        end else begin
            if (rx.valid && !(c_xon || c_xoff)) begin
                prev_term_q <= c_term && !pair_tail;
                prev_ch_q   <= ch;
            end
            if (c_esc || c_can) begin
                wptr_q   <= 7'h00; // R3 R9
                locked_q <= 1'b0;
            end else if (locked_q && line_done_in) begin
                wptr_q   <= 7'h00;
                locked_q <= 1'b0;
            end else if (do_term) begin
                locked_q <= 1'b1;
            end else if (do_bs) begin
                wptr_q <= wptr_q - 7'h01; // R4
            end else if (do_store) begin
                wptr_q <= wptr_q + 7'h01;
            end
        end
    end

    // transmit queue in flops, indexed ring
    logic [7:0]        txq_q [TXQ_DEPTH];
    logic [TXQ_AW:0]   head_q;
    logic [TXQ_AW:0]   tail_q;
    wire  [TXQ_AW:0]   used = tail_q - head_q;

    // enqueue requests built per event, up to three chars
    logic [7:0] e0, e1, e2;
    logic [1:0] en_n;
    wire  echo_bs   = mode_q.echo_en && do_bs;
    wire  echo_term = do_term;
    wire  done_ev   = locked_q && line_done_in && !(c_esc || c_can);

    always_comb begin
        e0   = 8'h00;
        e1   = 8'h00;
        e2   = 8'h00;
        en_n = 2'd0;
        if (c_esc) begin
            e0   = CH_CR; // R3
            e1   = CH_LF;
            en_n = 2'd2;
        end else if (echo_term) begin
            if (mode_q.flow_en) begin
                e0   = CH_XOFF; // R15
                e1   = CH_CR;
                en_n = mode_q.echo_en ? 2'd2 : 2'd1;
            end else if (mode_q.echo_en) begin
                e0   = ch; // R14
                en_n = 2'd1;
            end
        end else if (echo_bs) begin
            e0   = CH_BS; // R13
            e1   = CH_SP;
            e2   = CH_BS;
            en_n = 2'd3;
        end else if (mode_q.echo_en && do_store) begin
            e0   = ch; // R12
            en_n = 2'd1;
        end else if (done_ev) begin
            e0 = CH_CR; // R6
            e1 = CH_LF;
            e2 = CH_GT; // R19
            en_n = mode_q.prompt_en ? 2'd3 : 2'd2;
        end
    end

    wire [TXQ_AW:0] room    = (TXQ_AW+1)'(TXQ_DEPTH) - used;
    wire            fits    = ({3'b000, en_n} <= room);
    wire            overrun = (en_n != 2'd0) && !fits;
    logic           nak_pend_q;
    logic           bang_pend_q;
    wire            can_send = !tx_busy && !tx_go_q && !(xoff_q && mode_q.flow_en);
    wire            q_pop    = can_send && (used != '0);
    wire            send_nak = can_send && (used == '0) && nak_pend_q;
    wire            send_bng = can_send && (used == '0) && !nak_pend_q && bang_pend_q;

    // queue pointers and storage
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            head_q <= '0;
            tail_q <= '0;
        end else if (c_can) begin
            head_q <= '0; // R9
            tail_q <= '0;
        end else begin
            if (q_pop) begin
                head_q <= head_q + 1'b1;
            end
            if (fits) begin
                tail_q <= tail_q + (TXQ_AW+1)'(en_n);
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (fits && !c_can && en_n != 2'd0) begin
            txq_q[tail_q[TXQ_AW-1:0]] <= e0;
            if (en_n > 2'd1) txq_q[TXQ_AW'(tail_q + 1'b1)] <= e1;
            if (en_n > 2'd2) txq_q[TXQ_AW'(tail_q + 2'd2)] <= e2;
        end
    end

    // transmit launch, flow state, loss flags
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_go_q     <= 1'b0;
            tx_byte_q   <= 8'h00;
            xoff_q      <= 1'b0;
            nak_pend_q  <= 1'b0;
            bang_pend_q <= 1'b0;
            queue_loss_error_out <= 1'b0;
        end else begin
            tx_go_q <= q_pop || send_nak || send_bng;
            if (q_pop) begin
                tx_byte_q <= txq_q[head_q[TXQ_AW-1:0]];
            end else if (send_nak) begin
                tx_byte_q <= CH_NAK; // R17
            end else if (send_bng) begin
                tx_byte_q <= CH_BANG; // R11
            end
            if (c_xoff) begin
                xoff_q <= 1'b1; // R8
            end else if (c_xon || !mode_q.flow_en) begin
                xoff_q <= 1'b0; // R7
            end
            if (c_can) begin
                bang_pend_q <= 1'b0;
                nak_pend_q  <= 1'b0;
            end else begin
                if (c_xon) bang_pend_q <= 1'b1; // R11
                else if (send_bng) bang_pend_q <= 1'b0;
                if (overrun && mode_q.echo_en) nak_pend_q <= 1'b1; // R17
                else if (send_nak) nak_pend_q <= 1'b0;
            end
            queue_loss_error_out <= c_xoff || overrun; // R10 R17
        end
    end

    // software mode and status registers
    wire st_clr = wr_in && (addr_in == REG_STATUS) && wdata_in[ST_LOSS];
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            mode_q.flow_en   <= FLOW_EN_RST; // R1
            mode_q.echo_en   <= ECHO_EN_RST;
            mode_q.prompt_en <= PROMPT_EN_RST;
            mode_q.baud_div  <= BAUD_DIV_RST;
            loss_q           <= 1'b0;
            rdata_out        <= 32'h0000_0000;
        end else begin
            if (wr_in && addr_in == REG_MODE) begin
                mode_q.flow_en   <= wdata_in[0];
                mode_q.echo_en   <= wdata_in[1];
                mode_q.prompt_en <= wdata_in[2];
            end
            if (wr_in && addr_in == REG_BAUD && wdata_in[15:0] != 16'h0000) begin
                mode_q.baud_div <= wdata_in[15:0];
            end
            // set wins over clear
            if (c_xoff || overrun) loss_q <= 1'b1;
            else if (st_clr) loss_q <= 1'b0;
            rdata_out <= 32'h0000_0000;
            if (rd_in) begin
                case (addr_in)
                    REG_MODE:   rdata_out <= {29'h0, mode_q.prompt_en, mode_q.echo_en,
                                              mode_q.flow_en};
                    REG_BAUD:   rdata_out <= {16'h0000, mode_q.baud_div};
                    REG_STATUS: rdata_out <= {25'h0, wptr_q[3:0] != 4'h0, 3'b000,
                                              locked_q, loss_q, xoff_q};
                    default:    rdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    // parser view of the line
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            line_ready_out <= 1'b0;
            line_len_out   <= 7'h00;
            line_char_out  <= 8'h00;
        end else begin
            line_ready_out <= locked_q && !line_done_in && !(c_esc || c_can);
            line_len_out   <= wptr_q;
            line_char_out  <= line_mem_q[line_idx_in];
        end
    end
endmodule

// ---- dv/sclf_properties.sv ----
// port checks for the serial command line front end
`timescale 1ns/1ps
module sclf_properties
    import sclf_pkg::*;
(
    // every port of the top module
    input wire logic        clock_in,
    input wire logic        rst_n_in,
    input wire logic        rxd_in,
    input wire logic        txd_out,
    input wire logic [3:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic        line_ready_out,
    input wire logic [6:0]  line_len_out,
    input wire logic [6:0]  line_idx_in,
    input wire logic [7:0]  line_char_out,
    input wire logic        line_done_in,
    input wire logic        queue_loss_error_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    // read data only in the slot after a read strobe
    rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside read slot");
    unmapped_read_a: assert property ($past(rd_in) && $past(addr_in) == 4'hC
        |-> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    mode_bits_a: assert property ($past(rd_in) && $past(addr_in) == 4'h0
        |-> rdata_out[31:3] == 29'h0)
        else $error("mode word has stray bits");
    baud_nonzero_a: assert property ($past(rd_in) && $past(addr_in) == 4'h4
        |-> rdata_out[31:16] == 16'h0 && rdata_out[15:0] != 16'h0)
        else $error("baud divider zero or wide");
    status_bits_a: assert property ($past(rd_in) && $past(addr_in) == 4'h8
        |-> rdata_out[31:7] == 25'h0 && rdata_out[5:3] == 3'h0)
        else $error("status word has stray bits");
    // error post is a single pulse
    loss_pulse_a: assert property (queue_loss_error_out |=> !queue_loss_error_out)
        else $error("loss pulse longer than one cycle");
    // start bit lasts a whole bit; divider is never below 8 here
    start_bit_a: assert property ($fell(txd_out) |-> !txd_out [*8])
        else $error("start bit too short");
    // dispatch frees the line within two cycles
    done_clear_a: assert property (line_done_in && line_ready_out
        |-> ##[1:2] (!line_ready_out && line_len_out == 7'h0))
        else $error("line not freed after dispatch");

    cover property (line_done_in && line_ready_out);
    cover property (queue_loss_error_out);
    cover property ($fell(txd_out));
endmodule

// ---- dv/sclf_host.sv ----
// host terminal model: frames bytes onto the line and collects replies
`timescale 1ns/1ps
module sclf_host
    import sclf_pkg::*;
(
    // clock, bit time and serial line
    input  wire logic        clock_in,
    input  wire logic [15:0] div_in,
    input  wire logic        txd_in,
    output logic             rxd_out
);
    logic [7:0] got[$];
    logic       paused;
    logic [7:0] sh;

    initial begin
        rxd_out = 1'b1;
        paused  = 1'b0;
    end

    // one frame: start low, data lsb first, stop high; idles high after
    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        while (paused) @(posedge clock_in);
        for (int i = 0; i < 10; i++) begin
            @(posedge clock_in);
            rxd_out <= fr[i];
            repeat (div_in - 16'h1) @(posedge clock_in);
        end
    endtask

    // mid bit sampling; a bad stop bit is logged as a null byte
    initial forever begin
        @(negedge txd_in);
        repeat (div_in / 16'h2) @(posedge clock_in);
        for (int i = 0; i < 8; i++) begin
            repeat (div_in) @(posedge clock_in);
            sh[i] = txd_in;
        end
        repeat (div_in) @(posedge clock_in);
        if (sh == CH_XOFF)
            paused = 1'b1;
        got.push_back(txd_in ? sh : 8'h00);
    end
endmodule

// ---- dv/sclf_top_test.sv ----
// self-checking bench for the serial command line front end
`timescale 1ns/1ps
module sclf_top_test
    import sclf_pkg::*;
;
    logic        clock_in, rst_n_in, rxd, txd, wr_in, rd_in, line_done_in, loss;
    logic        line_ready_out;
    logic [3:0]  addr_in;
    logic [31:0] wdata_in, rdata_out, r;
    logic [6:0]  line_len_out, line_idx_in;
    logic [7:0]  line_char_out, c1, c2;
    logic [15:0] div;
    int          failures, checked, cycles, losses, seed, n0;
    logic [7:0]  exp_line[$];

    sclf_top i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .rxd_in(rxd), .txd_out(txd),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .line_ready_out(line_ready_out),
        .line_len_out(line_len_out), .line_idx_in(line_idx_in),
        .line_char_out(line_char_out), .line_done_in(line_done_in),
        .queue_loss_error_out(loss));
    sclf_host i_host (.clock_in(clock_in), .div_in(div), .txd_in(txd), .rxd_out(rxd));

    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    // watchdog; the run needs far fewer cycles
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (loss === 1'b1)
            losses <= losses + 1;
        if (cycles == 60000) begin
            failures = failures + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // next byte heard by the host; a missing byte counts as a mismatch
    task automatic tx_is(input logic [7:0] c);
        int n;
        n = 0;
        while (i_host.got.size() == 0 && n < 3000) begin
            @(posedge clock_in);
            n++;
        end
        if (i_host.got.size() == 0)
            chk(32'h100, {24'h0, c});
        else
            chk({24'h0, i_host.got.pop_front()}, {24'h0, c});
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    function automatic logic [7:0] rnd_char();
        return 8'h41 + 8'($random(seed) & 32'h1F);
    endfunction

    // editing model kept beside the stimulus
    task automatic key(input logic [7:0] c);
        if (c == CH_BS) begin
            if (exp_line.size() > 0)
                void'(exp_line.pop_back());
        end else if (c == CH_ESC || c == CH_CAN)
            exp_line.delete();
        else if (c > CTRL_TOP && exp_line.size() < 127)
            exp_line.push_back(c);
        i_host.send(c);
    endtask

    task automatic line_is();
        chk({31'h0, line_ready_out}, 32'h1);
        chk({25'h0, line_len_out}, exp_line.size());
        foreach (exp_line[i]) begin
            @(posedge clock_in);
            line_idx_in <= i[6:0];
            @(posedge clock_in);
            #1 chk({24'h0, line_char_out}, {24'h0, exp_line[i]});
        end
    endtask

    // parser pulse; bench then lets the host talk again
    task automatic done();
        @(posedge clock_in);
        line_done_in <= 1'b1;
        @(posedge clock_in);
        line_done_in <= 1'b0;
        exp_line.delete();
        i_host.paused = 1'b0;
    endtask

    initial begin
        {failures, checked, cycles, losses} = '0;
        seed = 86796;
        {rst_n_in, wr_in, rd_in, line_done_in, addr_in, wdata_in, line_idx_in} = '0;
        div = BAUD_DIV_RST;
        repeat (12) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        // reset values, refused writes, unmapped place
        rd(4'h0, r);
        chk(r, {29'h0, PROMPT_EN_RST, ECHO_EN_RST, FLOW_EN_RST});
        wr(4'h4, 32'h0);
        rd(4'h4, r);
        chk(r, {16'h0, BAUD_DIV_RST});
        rd(4'hC, r);
        chk(r, 32'h0);
        wr(4'h4, 32'h10);
        div = 16'h0010;
        // editing with every ignored control code; flow on, echo off
        for (int i = 0; i < 3; i++) key(rnd_char());
        for (int c = 0; c < 32; c++)
            if (!(c inside {8, 10, 13, 17, 19, 24, 27})) key(c[7:0]);
        key(CH_BS);
        key(rnd_char());
        key(CH_CR);
        tx_is(CH_XOFF);
        line_is();
        done();
        tx_is(CH_CR);
        tx_is(CH_LF);
        // echo on: chars, backspace triple, single terminator reply
        wr(4'h0, 32'h3);
        c1 = rnd_char();
        c2 = rnd_char();
        key(c1);
        tx_is(c1);
        key(c2);
        tx_is(c2);
        key(CH_BS);
        tx_is(CH_BS);
        tx_is(CH_SP);
        tx_is(CH_BS);
        key(CH_CR);
        key(CH_LF);
        tx_is(CH_XOFF);
        tx_is(CH_CR);
        line_is();
        done();
        tx_is(CH_CR);
        tx_is(CH_LF);
        // flow off, echo on: LF CR pair echoes the LF only
        wr(4'h0, 32'h2);
        c1 = rnd_char();
        key(c1);
        tx_is(c1);
        key(CH_LF);
        key(CH_CR);
        tx_is(CH_LF);
        line_is();
        done();
        tx_is(CH_CR);
        tx_is(CH_LF);
        repeat (400) @(posedge clock_in);
        chk(i_host.got.size(), 32'h0);
        // escape clears line and answers CR LF
        wr(4'h0, 32'h1);
        key(rnd_char());
        key(CH_ESC);
        tx_is(CH_CR);
        tx_is(CH_LF);
        chk({25'h0, line_len_out}, 32'h0);
        // halt, error post, release with bang
        n0 = losses;
        key(CH_XOFF);
        repeat (4) @(posedge clock_in);
        chk(losses - n0, 32'h1);
        rd(4'h8, r);
        chk(r, 32'h3);
        key(rnd_char());
        key(CH_ESC);
        repeat (400) @(posedge clock_in);
        chk(i_host.got.size(), 32'h0);
        key(CH_XON);
        tx_is(CH_CR);
        tx_is(CH_LF);
        tx_is(CH_BANG);
        wr(4'h8, 32'h2);
        rd(4'h8, r);
        chk(r, 32'h0);
        // echo overflow while halted: kept echoes, then NAK, then bang
        wr(4'h0, 32'h3);
        n0 = losses;
        key(CH_XOFF);
        for (int i = 0; i < TXQ_DEPTH + 1; i++) key(8'h41 + 8'(i));
        key(CH_ESC);
        repeat (4) @(posedge clock_in);
        chk(losses - n0, 32'h3);
        key(CH_XON);
        for (int i = 0; i < TXQ_DEPTH; i++) tx_is(8'h41 + 8'(i));
        tx_is(CH_NAK);
        tx_is(CH_BANG);
        // prompt after dispatch
        wr(4'h0, 32'h5);
        key(rnd_char());
        key(CH_CR);
        tx_is(CH_XOFF);
        line_is();
        done();
        tx_is(CH_CR);
        tx_is(CH_LF);
        tx_is(CH_GT);
        // cancel drops the held reply
        key(CH_XOFF);
        key(rnd_char());
        key(CH_ESC);
        key(CH_CAN);
        key(CH_XON);
        tx_is(CH_BANG);
        repeat (400) @(posedge clock_in);
        chk(i_host.got.size(), 32'h0);
        chk({25'h0, line_len_out}, 32'h0);
        wrap_up();
    end
endmodule

bind sclf_top sclf_properties u_props (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .rxd_in(rxd_in), .txd_out(txd_out), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .line_ready_out(line_ready_out),
    .line_len_out(line_len_out), .line_idx_in(line_idx_in), .line_char_out(line_char_out),
    .line_done_in(line_done_in), .queue_loss_error_out(queue_loss_error_out));
